// >>> hw/sdp_defs.svh
// constants for the dual sdram pin interface: widths, strobe codes, timing counts
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH

`define SDP_SYS_DW 64
`define SDP_SYS_MW 8
`define SDP_DC_DW 32
`define SDP_DC_MW 4
`define SDP_AW 12
`define SDP_CS_N 4
`define SDP_BANK_W 2
`define SDP_CKE_N 2

// active-low {row strobe, column strobe, write enable} command codes
`define SDP_CMD_NOP 3'h7
`define SDP_CMD_ACT 3'h3
`define SDP_CMD_READ 3'h5
`define SDP_CMD_WRITE 3'h4
`define SDP_CMD_PRE 3'h2
`define SDP_CMD_REF 3'h1
`define SDP_CMD_MRS 3'h0

// idle pin levels, also the reset values, plus the clock-enable level held in suspend
`define SDP_CS_IDLE 4'hf
`define SDP_CKE_ON 2'h3
`define SDP_CKE_OFF 2'h0
`define SDP_SYS_MASK_IDLE 8'hff
`define SDP_DC_MASK_IDLE 4'hf

// timing
`define SDP_CLK_PERIOD_NS 10
`define SDP_EXIT_NS 80
`define SDP_EXIT_CYC ((`SDP_EXIT_NS + `SDP_CLK_PERIOD_NS - 1) / `SDP_CLK_PERIOD_NS)
`define SDP_CAS_LAT 2
`define SDP_BUF_DEPTH 2

`endif

// >>> hw/sdp_pkg.sv
// types shared by the dual sdram pin interface
package sdp_pkg;
    `include "sdp_defs.svh"

    typedef enum logic [2:0] {
        SDP_OP_NOP, SDP_OP_ACT, SDP_OP_READ, SDP_OP_WRITE, SDP_OP_PRE, SDP_OP_REF, SDP_OP_MRS
    } sdp_op_t;

    typedef enum logic {SDP_PORT_SYS, SDP_PORT_DC} sdp_port_t;

    typedef enum logic [1:0] {SDP_ST_RUN, SDP_ST_SUSP, SDP_ST_EXIT} sdp_susp_st_t;

    typedef struct packed {
        sdp_port_t port;
        sdp_op_t op;
        logic [1:0] cs_idx;
        logic [`SDP_BANK_W-1:0] bank;
        logic [`SDP_AW-1:0] addr;
        logic [`SDP_SYS_MW-1:0] byte_en;
        logic [`SDP_SYS_DW-1:0] wdata;
    } sdp_cmd_t;

    typedef struct packed {
        logic [`SDP_AW-1:0] addr;
        logic [3:0] addr_copy_n;
        logic [`SDP_BANK_W-1:0] bank;
        logic [`SDP_CS_N-1:0] cs_n;
        logic [2:0] strobe_n;
        logic [`SDP_CKE_N-1:0] cke;
        logic [`SDP_SYS_MW-1:0] mask;
        logic [`SDP_SYS_DW-1:0] dq_out;
        logic dq_oe;
    } sdp_sys_pins_t;

    typedef struct packed {
        logic cs_n;
        logic [2:0] strobe_n;
        logic [`SDP_AW-1:0] addr;
        logic [`SDP_DC_MW-1:0] mask;
        logic [`SDP_DC_DW-1:0] dq_out;
        logic dq_oe;
    } sdp_dc_pins_t;

    typedef struct packed {
        sdp_port_t port;
        logic [`SDP_SYS_DW-1:0] data;
    } sdp_rd_t;

    function automatic logic [2:0] sdp_strobes(input sdp_op_t op);
        case (op)
            SDP_OP_ACT: return `SDP_CMD_ACT;
            SDP_OP_READ: return `SDP_CMD_READ;
            SDP_OP_WRITE: return `SDP_CMD_WRITE;
            SDP_OP_PRE: return `SDP_CMD_PRE;
            SDP_OP_REF: return `SDP_CMD_REF;
            SDP_OP_MRS: return `SDP_CMD_MRS;
            default: return `SDP_CMD_NOP;
        endcase
    endfunction
endpackage

// >>> hw/sdp_buf.sv
// small valid/ready buffer with registered full and empty flags
`timescale 1ns/1ns
module sdp_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic full;
        logic empty;
    } sdp_buf_state_t;

    sdp_buf_state_t q;
    sdp_buf_state_t d;
    logic push;
    logic pop;

    assign in_ready = !q.full;
    assign out_valid = !q.empty;
    assign out_data = q.mem[q.rd_ptr];
    assign push = in_valid && !q.full;
    assign pop = out_ready && !q.empty;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : q.wr_ptr + PW'(1);
        end
        if (pop) begin
            d.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : q.rd_ptr + PW'(1);
        end
        if (push && !pop) begin
            d.count = q.count + CW'(1);
        end else if (pop && !push) begin
            d.count = q.count - CW'(1);
        end
        d.full = (d.count == CW'(DEPTH));
        d.empty = (d.count == '0);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
            q.empty <= 1'h1;
        end else begin
            q <= d;
        end
    end
endmodule

// >>> hw/sdp_pin_if.sv
// controller-side pin logic for a system sdram port and a display-cache sdram port
`timescale 1ns/1ns
module sdp_pin_if import sdp_pkg::*; #(
    parameter int CAS_LAT = `SDP_CAS_LAT,
    parameter int EXIT_CYC = `SDP_EXIT_CYC,
    parameter int BUF_DEPTH = `SDP_BUF_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // command stream
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sdp_cmd_t cmd,
    // suspend control
    input wire logic suspend_req,
    input wire logic suspend_self_refresh,
    output logic suspend_ack,
    // read data return
    output logic rd_valid,
    output sdp_rd_t rd,
    // system memory pins
    output logic [`SDP_AW-1:0] sys_mem_addr,
    output logic [3:0] sys_mem_addr_copy_n,
    output logic [`SDP_BANK_W-1:0] sys_bank_sel,
    output logic [`SDP_CS_N-1:0] sys_chip_sel_n,
    output logic sys_row_strobe_n,
    output logic sys_col_strobe_n,
    output logic sys_write_en_n,
    output logic [`SDP_CKE_N-1:0] sys_clk_en,
    output logic [`SDP_SYS_MW-1:0] sys_byte_mask,
    input wire logic [`SDP_SYS_DW-1:0] sys_mem_dq_in,
    output logic [`SDP_SYS_DW-1:0] sys_mem_dq_out,
    output logic sys_mem_dq_oe,
    // display-cache pins
    output logic dc_chip_sel_n,
    output logic dc_row_strobe_n,
    output logic dc_row_strobe_alias_n,
    output logic dc_col_strobe_n,
    output logic dc_write_en_n,
    output logic [`SDP_AW-1:0] dc_addr,
    output logic [`SDP_DC_MW-1:0] dc_byte_mask,
    input wire logic [`SDP_DC_DW-1:0] dc_dq_in,
    output logic [`SDP_DC_DW-1:0] dc_dq_out,
    output logic dc_dq_oe
);
    typedef struct packed {
        sdp_susp_st_t st;
        logic [7:0] exit_cnt;
        logic ack;
        sdp_sys_pins_t sys;
        sdp_dc_pins_t dc;
        logic [CAS_LAT:0] rd_pipe;
        logic [CAS_LAT:0] rd_dc_pipe;
        logic rd_valid;
        sdp_rd_t rd;
    } sdp_state_t;

    sdp_state_t q;
    sdp_state_t d;

    logic buf_valid;
    logic buf_ready;
    logic [$bits(sdp_cmd_t)-1:0] buf_data;
    sdp_cmd_t head;
    logic sys_rd_busy;
    logic dc_rd_busy;
    logic turn_hazard;

    // two-entry buffer: a stall here pushes back on cmd_ready, so no command is lost
    sdp_buf #(
        .WIDTH($bits(sdp_cmd_t)),
        .DEPTH(BUF_DEPTH)
    ) i_sdp_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    assign head = sdp_cmd_t'(buf_data);

    // read data still due back on a bus would collide with our write data
    assign sys_rd_busy = |(q.rd_pipe[CAS_LAT-1:0] & ~q.rd_dc_pipe[CAS_LAT-1:0]);
    assign dc_rd_busy = |(q.rd_pipe[CAS_LAT-1:0] & q.rd_dc_pipe[CAS_LAT-1:0]);
    assign turn_hazard = (head.op == SDP_OP_WRITE) &&
        ((head.port == SDP_PORT_SYS) ? sys_rd_busy : dc_rd_busy);

    // commands leave the buffer only while running and not asked to suspend
    assign buf_ready = (q.st == SDP_ST_RUN) && !suspend_req && !turn_hazard;

    always_comb begin
        d = q;
        // idle pins every cycle unless a command below claims them
        d.sys.cs_n = `SDP_CS_IDLE;
        d.sys.strobe_n = `SDP_CMD_NOP;
        d.sys.mask = `SDP_SYS_MASK_IDLE;
        d.sys.dq_oe = 1'h0;
        d.dc.cs_n = 1'h1;
        d.dc.strobe_n = `SDP_CMD_NOP;
        d.dc.mask = `SDP_DC_MASK_IDLE;
        d.dc.dq_oe = 1'h0;

        // read return: data is on the bus CAS_LAT edges after the command edge
        d.rd_pipe = {q.rd_pipe[CAS_LAT-1:0], 1'h0};
        d.rd_dc_pipe = {q.rd_dc_pipe[CAS_LAT-1:0], 1'h0};
        d.rd_valid = q.rd_pipe[CAS_LAT];
        if (q.rd_pipe[CAS_LAT]) begin
            if (q.rd_dc_pipe[CAS_LAT]) begin
                d.rd.port = SDP_PORT_DC;
                d.rd.data = {{(`SDP_SYS_DW - `SDP_DC_DW){1'h0}}, dc_dq_in};
            end else begin
                d.rd.port = SDP_PORT_SYS;
                d.rd.data = sys_mem_dq_in;
            end
        end

        case (q.st)
            SDP_ST_RUN: begin
                if (suspend_req) begin
                    // pending commands stay buffered and go out after wake-up
                    d.sys.cke = `SDP_CKE_OFF;
                    if (suspend_self_refresh) begin
                        d.sys.cs_n = '0;
                        d.sys.strobe_n = `SDP_CMD_REF;
                    end
                    d.ack = 1'h1;
                    d.st = SDP_ST_SUSP;
                end else if (buf_valid && buf_ready) begin
                    if (head.port == SDP_PORT_SYS) begin
                        d.sys.addr = head.addr;
                        d.sys.addr_copy_n = ~head.addr[7:4];
                        d.sys.bank = head.bank;
                        if (head.op != SDP_OP_NOP) begin
                            d.sys.cs_n = ~(`SDP_CS_N'(1) << head.cs_idx);
                        end
                        d.sys.strobe_n = sdp_strobes(head.op);
                        if (head.op == SDP_OP_READ || head.op == SDP_OP_WRITE) begin
                            d.sys.mask = ~head.byte_en;
                        end
                        if (head.op == SDP_OP_WRITE) begin
                            d.sys.dq_out = head.wdata;
                            d.sys.dq_oe = 1'h1;
                        end
                        if (head.op == SDP_OP_READ) begin
                            d.rd_pipe[0] = 1'h1;
                            d.rd_dc_pipe[0] = 1'h0;
                        end
                    end else begin
                        d.dc.addr = head.addr;
                        if (head.op != SDP_OP_NOP) begin
                            d.dc.cs_n = 1'h0;
                        end
                        d.dc.strobe_n = sdp_strobes(head.op);
                        if (head.op == SDP_OP_READ || head.op == SDP_OP_WRITE) begin
                            d.dc.mask = ~head.byte_en[`SDP_DC_MW-1:0];
                        end
                        if (head.op == SDP_OP_WRITE) begin
                            d.dc.dq_out = head.wdata[`SDP_DC_DW-1:0];
                            d.dc.dq_oe = 1'h1;
                        end
                        if (head.op == SDP_OP_READ) begin
                            d.rd_pipe[0] = 1'h1;
                            d.rd_dc_pipe[0] = 1'h1;
                        end
                    end
                end
            end
            SDP_ST_SUSP: begin
                // clock enables held low for the whole suspend
                if (!suspend_req) begin
                    d.sys.cke = `SDP_CKE_ON;
                    d.exit_cnt = 8'(EXIT_CYC);
                    d.st = SDP_ST_EXIT;
                end
            end
            SDP_ST_EXIT: begin
                // only nops until the array has left self refresh or power-down
                d.exit_cnt = q.exit_cnt - 8'h01;
                if (q.exit_cnt <= 8'h01) begin
                    d.ack = 1'h0;
                    d.st = SDP_ST_RUN;
                end
            end
            default: begin
                d.st = SDP_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
            q.sys.cs_n <= `SDP_CS_IDLE;
            q.sys.strobe_n <= `SDP_CMD_NOP;
            q.sys.cke <= `SDP_CKE_ON;
            q.sys.mask <= `SDP_SYS_MASK_IDLE;
            q.sys.addr_copy_n <= 4'hf;
            q.dc.cs_n <= 1'h1;
            q.dc.strobe_n <= `SDP_CMD_NOP;
            q.dc.mask <= `SDP_DC_MASK_IDLE;
        end else begin
            q <= d;
        end
    end

    // every pin below is a flip-flop output
    assign suspend_ack = q.ack;
    assign rd_valid = q.rd_valid;
    assign rd = q.rd;

    assign sys_mem_addr = q.sys.addr;
    assign sys_mem_addr_copy_n = q.sys.addr_copy_n;
    assign sys_bank_sel = q.sys.bank;
    assign sys_chip_sel_n = q.sys.cs_n;
    assign sys_row_strobe_n = q.sys.strobe_n[2];
    assign sys_col_strobe_n = q.sys.strobe_n[1];
    assign sys_write_en_n = q.sys.strobe_n[0];
    assign sys_clk_en = q.sys.cke;
    assign sys_byte_mask = q.sys.mask;
    assign sys_mem_dq_out = q.sys.dq_out;
    assign sys_mem_dq_oe = q.sys.dq_oe;

    assign dc_chip_sel_n = q.dc.cs_n;
    assign dc_row_strobe_n = q.dc.strobe_n[2];
    assign dc_row_strobe_alias_n = q.dc.strobe_n[2];
    assign dc_col_strobe_n = q.dc.strobe_n[1];
    assign dc_write_en_n = q.dc.strobe_n[0];
    assign dc_addr = q.dc.addr;
    assign dc_byte_mask = q.dc.mask;
    assign dc_dq_out = q.dc.dq_out;
    assign dc_dq_oe = q.dc.dq_oe;
endmodule

// >>> tb/sdp_pin_if_props.sv
// concurrent checks on the pins of the dual sdram pin interface
`timescale 1ns/1ns
module sdp_pin_if_props import sdp_pkg::*; #(
    parameter int CAS_LAT = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic suspend_req,
    input wire logic suspend_ack,
    input wire logic rd_valid,
    // system pins
    input wire logic [11:0] sys_mem_addr,
    input wire logic [3:0] sys_mem_addr_copy_n,
    input wire logic [3:0] sys_chip_sel_n,
    input wire logic sys_row_strobe_n,
    input wire logic sys_col_strobe_n,
    input wire logic sys_write_en_n,
    input wire logic [1:0] sys_clk_en,
    input wire logic [7:0] sys_byte_mask,
    input wire logic sys_mem_dq_oe,
    // display-cache pins
    input wire logic dc_chip_sel_n,
    input wire logic dc_row_strobe_n,
    input wire logic dc_row_strobe_alias_n,
    input wire logic dc_col_strobe_n,
    input wire logic dc_write_en_n,
    input wire logic dc_dq_oe
);
    localparam int RL = CAS_LAT + 1;
    wire [2:0] ss = {sys_row_strobe_n, sys_col_strobe_n, sys_write_en_n};
    wire [2:0] ds = {dc_row_strobe_n, dc_col_strobe_n, dc_write_en_n};
    wire rd_cmd = (ss == 3'h5 && sys_chip_sel_n != 4'hf) || (ds == 3'h5 && !dc_chip_sel_n);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    addr_copy_a: assert property (sys_mem_addr_copy_n == ~sys_mem_addr[7:4])
        else $error("address copy not inverted");
    one_select_a: assert property (sys_chip_sel_n != 4'hf && sys_clk_en == 2'h3 |-> $onehot(~sys_chip_sel_n))
        else $error("chip selects not one-hot");
    sys_drive_a: assert property (sys_mem_dq_oe |-> ss == 3'h4 && sys_chip_sel_n != 4'hf)
        else $error("system bus driven outside write");
    dc_drive_a: assert property (dc_dq_oe |-> ds == 3'h4 && !dc_chip_sel_n)
        else $error("display bus driven outside write");
    idle_mask_a: assert property (ss[2:1] != 2'b10 |-> sys_byte_mask == 8'hff)
        else $error("mask active outside data command");
    row_alias_a: assert property (dc_row_strobe_alias_n == dc_row_strobe_n)
        else $error("row strobe copy differs");
    susp_entry_a: assert property (suspend_req && !suspend_ack |=> suspend_ack && sys_clk_en == 2'h0)
        else $error("suspend entry late");
    exit_quiet_a: assert property (suspend_ack && sys_clk_en == 2'h3 |-> ss == 3'h7 && sys_chip_sel_n == 4'hf)
        else $error("command during suspend exit");
    read_return_a: assert property (rd_cmd |-> ##RL rd_valid)
        else $error("read word late");
    cover property ($rose(suspend_ack) && sys_chip_sel_n == 4'h0);
    cover property (rd_valid);
    cover property (dc_dq_oe);
endmodule

bind sdp_pin_if sdp_pin_if_props #(.CAS_LAT(CAS_LAT)) i_sdp_pin_if_props (.*);

// >>> tb/sdp_mem_model.sv
// sdram device model, one instance per port
`timescale 1ns/1ns
module sdp_mem_model import sdp_pkg::*; #(
    parameter int W = 64,
    parameter int MW = 8,
    parameter int CL = 2
) (
    // pins from the controller
    input wire logic sys_clk,
    input wire logic cs_n,
    input wire logic [2:0] cmd,
    input wire logic [11:0] addr,
    input wire logic [MW-1:0] mask,
    input wire logic [W-1:0] dq_out,
    // data back to the controller
    output logic [W-1:0] dq_in
);
    logic [W-1:0] mem [32];
    logic [W:0] pipe [CL];
    logic [W-1:0] last = '0;
    logic [11:0] row_q = '0;
    wire [4:0] idx = {row_q[1:0], addr[2:0]};
    initial begin
        for (int k = 0; k < 32; k++) mem[k] = '0;
        for (int k = 0; k < CL; k++) pipe[k] = '0;
    end
    always @(posedge sys_clk) begin
        if (!cs_n && cmd == 3'h3) row_q <= addr;
        for (int k = 0; k < MW; k++) begin
            if (!cs_n && cmd == 3'h4 && !mask[k]) mem[idx][k*8+:8] <= dq_out[k*8+:8];
        end
        pipe[0] <= {!cs_n && cmd == 3'h5, mem[idx]};
        for (int k = 1; k < CL; k++) pipe[k] <= pipe[k-1];
        if (pipe[CL-1][W]) last <= pipe[CL-1][W-1:0];
    end
    // a released bus shows the inverse of the last word so a stale sample cannot match
    assign dq_in = pipe[CL-1][W] ? pipe[CL-1][W-1:0] : ~last;
endmodule

// >>> tb/test_sdp_pin_if.sv
// self-checking bench for the dual sdram pin interface
`timescale 1ns/1ns
module test_sdp_pin_if import sdp_pkg::*; ;
    logic sys_clk = 0, reset = 1, cmd_valid = 0, suspend_req = 0, suspend_self_refresh = 0;
    sdp_cmd_t cmd = '0;
    logic cmd_ready, suspend_ack, rd_valid, sys_row_strobe_n, sys_col_strobe_n, sys_write_en_n, sys_mem_dq_oe;
    sdp_rd_t rd;
    logic [11:0] sys_mem_addr, dc_addr;
    logic [3:0] sys_mem_addr_copy_n, sys_chip_sel_n, dc_byte_mask;
    logic [1:0] sys_bank_sel, sys_clk_en;
    logic [7:0] sys_byte_mask;
    logic [63:0] sys_mem_dq_in, sys_mem_dq_out;
    logic dc_chip_sel_n, dc_row_strobe_n, dc_row_strobe_alias_n, dc_col_strobe_n, dc_write_en_n, dc_dq_oe;
    logic [31:0] dc_dq_in, dc_dq_out;
    int num_errors = 0, checks = 0;
    always #5 sys_clk = ~sys_clk;
    // short exit wait keeps suspend scenarios brief
    sdp_pin_if #(.EXIT_CYC(1)) i_sdp_pin_if (.*);
    sdp_mem_model #(.W(64), .MW(8)) i_sys_mem (.sys_clk(sys_clk), .cs_n(&sys_chip_sel_n),
        .cmd({sys_row_strobe_n, sys_col_strobe_n, sys_write_en_n}), .addr(sys_mem_addr),
        .mask(sys_byte_mask), .dq_out(sys_mem_dq_out), .dq_in(sys_mem_dq_in));
    sdp_mem_model #(.W(32), .MW(4)) i_dc_mem (.sys_clk(sys_clk), .cs_n(dc_chip_sel_n),
        .cmd({dc_row_strobe_n, dc_col_strobe_n, dc_write_en_n}), .addr(dc_addr),
        .mask(dc_byte_mask), .dq_out(dc_dq_out), .dq_in(dc_dq_in));
    task automatic close_out;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
        checks++;
        if (e !== s) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic hung(string nm);
        num_errors++;
        $display("[ERR] %s expected handshake seen none", nm);
        close_out;
    endtask
    task automatic send(sdp_port_t p, sdp_op_t o, logic [1:0] c, logic [11:0] a, logic [7:0] be, logic [63:0] d);
        int n;
        cmd = '{p, o, c, c, a, be, d};
        cmd_valid = 1'b1;
        for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
        if (cmd_ready !== 1'b1) hung("cmd_ready");
        @(negedge sys_clk);
    endtask
    // waits for the next command cycle of a port and checks its command, address, mask and data pins
    task automatic see(sdp_port_t p, logic [2:0] s, logic [1:0] c, logic [11:0] a, logic [7:0] be, logic [63:0] d);
        int n;
        logic wr;
        wr = (s == 3'h4);
        for (n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (p == SDP_PORT_SYS ? sys_chip_sel_n != 4'hf : dc_chip_sel_n == 1'b0) break;
        end
        if (n == 40) hung("command pins");
        if (p == SDP_PORT_SYS) begin
            chk("sys strobes", s, {sys_row_strobe_n, sys_col_strobe_n, sys_write_en_n});
            chk("sys chip select", 4'(~(4'h1 << c)), sys_chip_sel_n);
            chk("sys bank", c, sys_bank_sel);
            chk("sys addr", {~a[7:4], a}, {sys_mem_addr_copy_n, sys_mem_addr});
            chk("sys mask", 8'(s[2:1] == 2'b10 ? ~be : 8'hff), sys_byte_mask);
            chk("sys oe", wr, sys_mem_dq_oe);
            if (wr) chk("sys data", d, sys_mem_dq_out);
        end else begin
            chk("dc strobes", s, {dc_row_strobe_n, dc_col_strobe_n, dc_write_en_n});
            chk("dc addr", a, dc_addr);
            chk("dc mask", 4'(s[2:1] == 2'b10 ? ~be[3:0] : 4'hf), dc_byte_mask);
            chk("dc oe", wr, dc_dq_oe);
            if (wr) chk("dc data", d[31:0], dc_dq_out);
        end
    endtask
    task automatic xfer(sdp_port_t p, sdp_op_t o, logic [2:0] s, logic [1:0] c, logic [11:0] a, logic [7:0] be,
        logic [63:0] d);
        send(p, o, c, a, be, d);
        cmd_valid = 1'b0;
        see(p, s, c, a, be, d);
    endtask
    task automatic get_rd(sdp_port_t p, logic [63:0] e);
        int n;
        for (n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge sys_clk);
        if (rd_valid !== 1'b1) hung("rd_valid");
        chk("read port", p, rd.port);
        chk("read data", e, rd.data);
    endtask
    task automatic t_reset;
        chk("idle chip selects", 4'hf, sys_chip_sel_n);
        chk("idle clock enables", 2'h3, sys_clk_en);
        chk("idle dc pins", 5'h1f, {dc_chip_sel_n, dc_row_strobe_n, dc_col_strobe_n, dc_write_en_n, dc_row_strobe_alias_n});
        chk("idle masks", 12'hfff, {sys_byte_mask, dc_byte_mask});
        chk("idle drive", 2'h0, {sys_mem_dq_oe, dc_dq_oe});
    endtask
    task automatic t_sys;
        logic [63:0] a;
        for (int c = 0; c < 4; c++) begin
            a = 64'h0123_4567_89ab_cdef + 64'(c);
            xfer(SDP_PORT_SYS, SDP_OP_ACT, 3'h3, 2'(c), 12'(12'h0a0 + c), 8'hff, 0);
            xfer(SDP_PORT_SYS, SDP_OP_WRITE, 3'h4, 2'(c), 12'h0f5, 8'hff, a);
            xfer(SDP_PORT_SYS, SDP_OP_WRITE, 3'h4, 2'(c), 12'h0f5, 8'h0f, ~a);
            xfer(SDP_PORT_SYS, SDP_OP_READ, 3'h5, 2'(c), 12'h0f5, 8'hff, 0);
            get_rd(SDP_PORT_SYS, {a[63:32], ~a[31:0]});
        end
    endtask
    task automatic t_dc;
        xfer(SDP_PORT_DC, SDP_OP_ACT, 3'h3, 0, 12'h3c1, 8'h00, 0);
        xfer(SDP_PORT_DC, SDP_OP_WRITE, 3'h4, 0, 12'h002, 8'h0f, 64'h1122_3344);
        xfer(SDP_PORT_DC, SDP_OP_WRITE, 3'h4, 0, 12'h002, 8'h05, 64'haabb_ccdd);
        xfer(SDP_PORT_DC, SDP_OP_READ, 3'h5, 0, 12'h002, 8'h0f, 0);
        get_rd(SDP_PORT_DC, 64'h11bb_33dd);
    endtask
    task automatic t_ops;
        // a nop moves the address but leaves selects and strobes idle
        send(SDP_PORT_SYS, SDP_OP_NOP, 2, 12'h155, 8'h00, 0);
        cmd_valid = 1'b0;
        @(negedge sys_clk);
        chk("nop pins", 7'h7f, {sys_chip_sel_n, sys_row_strobe_n, sys_col_strobe_n, sys_write_en_n});
        chk("nop addr", 12'h155, sys_mem_addr);
        xfer(SDP_PORT_SYS, SDP_OP_PRE, 3'h2, 1, 12'h400, 8'hff, 0);
        xfer(SDP_PORT_SYS, SDP_OP_REF, 3'h1, 2, 12'h000, 8'hff, 0);
        xfer(SDP_PORT_SYS, SDP_OP_MRS, 3'h0, 3, 12'h022, 8'hff, 0);
        xfer(SDP_PORT_DC, SDP_OP_PRE, 3'h2, 0, 12'h400, 8'hff, 0);
    endtask
    // commands offered in suspend stay buffered and leave back to back after exit
    task automatic t_susp(logic sr);
        suspend_self_refresh = sr;
        suspend_req = 1'b1;
        @(negedge sys_clk);
        chk("suspend clock enables", 2'h0, sys_clk_en);
        chk("suspend ack", 1'b1, suspend_ack);
        chk("suspend command", sr ? 7'h01 : 7'h7f, {sys_chip_sel_n, sys_row_strobe_n, sys_col_strobe_n, sys_write_en_n});
        send(SDP_PORT_SYS, SDP_OP_ACT, 1, 12'h0a1, 8'hff, 0);
        send(SDP_PORT_SYS, SDP_OP_READ, 1, 12'h0f5, 8'hff, 0);
        chk("buffer full", 0, cmd_ready);
        cmd_valid = 1'b0;
        suspend_req = 1'b0;
        see(SDP_PORT_SYS, 3'h3, 1, 12'h0a1, 8'hff, 0);
        see(SDP_PORT_SYS, 3'h5, 1, 12'h0f5, 8'hff, 0);
        chk("resume clock enables", 2'h3, sys_clk_en);
        chk("resume ack", 1'b0, suspend_ack);
        get_rd(SDP_PORT_SYS, {32'h0123_4567, ~32'h89ab_cdf0});
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        t_reset;
        t_sys;
        t_dc;
        t_ops;
        t_susp(1'b1);
        t_susp(1'b0);
        close_out;
    end
endmodule
